//--- common/its_pkg.sv
// Package for the bus supervision timer and status block
// Function
// - All enables off, run clear: interface off, timer cleared
// - Enables off, run set: timer free-runs
// - Enabled, run clear: only low three bits count
// - Enabled and running: count in frames, clear on start or stop
// - Timing select maps to counts and timeouts
// - Status mirrors idle, repeated start, stop commands
// - Status shows tx buffer bit and tx active
// - Status bit three shows start generation
// - Status bit two shows stop generation
// - Repeated start bit active while being sent
// - Stop bit active while being sent
// - Clock edge preloads eight minus minimum count
// - Reset clears timing select
// - Timeout clears ownership request and slave enable
// - Minimum time counts once per machine cycle of twelve core clocks
package its_pkg;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_TIMER = 8'h14;
  // Config fields
  localparam int CFG_SLAVE_EN = 7;
  localparam int CFG_OWN_REQ = 6;
  localparam int CFG_CLR_TFLAG = 5;
  localparam int CFG_RUN = 4;
  localparam int CFG_TSEL_HI = 1;
  localparam int CFG_TSEL_LO = 0;
  // Control and status fields
  localparam int ST_SPARE = 7;
  localparam int ST_IDLE = 6;
  localparam int ST_TX_BIT = 5;
  localparam int ST_TX_ACT = 4;
  localparam int ST_MK_START = 3;
  localparam int ST_MK_STOP = 2;
  localparam int ST_RSTART = 1;
  localparam int ST_STOP = 0;
  localparam int IRQ_TFLAG = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] TSEL_RESET = 2'h0;
  localparam logic [9:0] TIMER_RESET = 10'h000;
  localparam logic [9:0] TIMER_MAX = 10'h3ff;
  localparam logic [2:0] LOW_MAX = 3'h7;
  localparam logic [3:0] MIN_MARK = 4'h8;
  // Minimum clock high/low counts per timing select code
  localparam logic [2:0] MIN_CNT_SEL10 = 3'h7;
  localparam logic [2:0] MIN_CNT_SEL01 = 3'h6;
  localparam logic [2:0] MIN_CNT_SEL00 = 3'h5;
  localparam logic [2:0] MIN_CNT_SEL11 = 3'h4;
  // Clock and machine cycle
  localparam int CORE_CLK_HZ = 25000000;
  localparam int OSC_PER_MCYCLE = 12;
  localparam logic [3:0] MCYC_LAST = 4'(OSC_PER_MCYCLE - 1);
  typedef enum logic [1:0] {
    ITS_OFF = 2'b00,
    ITS_FREE = 2'b01,
    ITS_MIN = 2'b10,
    ITS_SUPERVISE = 2'b11
  } its_mode_t;
  // Inputs from the bus engine
  typedef struct packed {
    logic master_state;
    logic frame_active;
    logic scl_edge;
    logic start_det;
    logic stop_det;
    logic tx_buffer_bit;
    logic tx_active_flag;
    logic making_start_flag;
    logic making_stop_flag;
    logic rstart_done;
    logic stop_done;
  } its_eng_in_t;
  // Outputs to the bus engine
  typedef struct packed {
    logic bus_enable;
    logic slave_function_enable;
    logic bus_ownership_request;
    logic [1:0] scl_timing_select;
    logic idle_cmd;
    logic send_repeated_start;
    logic send_stop_cmd;
    logic min_time_elapsed;
    logic bus_timeout;
  } its_eng_out_t;
endpackage : its_pkg

//--- rtl/its_supervisor.sv
// Supervision timer, mode control and status readout with APB slave
`timescale 1ns/10ps
module its_supervisor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus engine
  input its_pkg::its_eng_in_t eng_in,
  output its_pkg::its_eng_out_t eng_out,
  // Interrupt
  output logic irq
);

  function automatic logic [2:0] min_count(input logic [1:0] sel);
    unique case (sel)
      2'h2: min_count = its_pkg::MIN_CNT_SEL10;
      2'h1: min_count = its_pkg::MIN_CNT_SEL01;
      2'h0: min_count = its_pkg::MIN_CNT_SEL00;
      2'h3: min_count = its_pkg::MIN_CNT_SEL11;
    endcase
  endfunction : min_count

  function automatic logic [9:0] preload(input logic [1:0] sel);
    preload = 10'(its_pkg::MIN_MARK - {1'b0, min_count(sel)});
  endfunction : preload

  logic slave_en_q;
  logic own_req_q;
  logic run_q;
  logic [1:0] tsel_q;
  logic idle_q;
  logic rstart_q;
  logic stop_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [9:0] timer_q;
  logic min_done_q;
  logic [3:0] div_q;
  logic mtick;
  logic enabled;
  logic ovf;
  logic timeout;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic addr_ok;
  logic wr;
  logic setup;
  logic [7:0] status;
  its_pkg::its_mode_t mode;

  // APB decode, zero wait states
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign addr_ok = paddr == its_pkg::OFS_CONFIG || paddr == its_pkg::OFS_CONTROL
    || paddr == its_pkg::OFS_STATUS || paddr == its_pkg::OFS_IRQ_STAT
    || paddr == its_pkg::OFS_IRQ_MASK || paddr == its_pkg::OFS_TIMER;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Machine cycle enable, one in twelve core clocks
  always_ff @(posedge core_clk)
  begin
    if (rst || div_q == its_pkg::MCYC_LAST)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end
  assign mtick = div_q == its_pkg::MCYC_LAST;

  assign enabled = slave_en_q || own_req_q || eng_in.master_state;
  assign mode = its_pkg::its_mode_t'({enabled, run_q});
  assign ovf = mtick && timer_q == its_pkg::TIMER_MAX && run_q
    && (mode == its_pkg::ITS_FREE || (mode == its_pkg::ITS_SUPERVISE && eng_in.frame_active));
  assign timeout = ovf && mode == its_pkg::ITS_SUPERVISE;

  // Configuration register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      slave_en_q <= 1'b0;
      own_req_q <= 1'b0;
      run_q <= 1'b0;
      tsel_q <= its_pkg::TSEL_RESET;
    end
    else if (timeout)
    begin
      slave_en_q <= 1'b0;
      own_req_q <= 1'b0;
    end
    else if (wr && paddr == its_pkg::OFS_CONFIG)
    begin
      slave_en_q <= pwdata[its_pkg::CFG_SLAVE_EN];
      own_req_q <= pwdata[its_pkg::CFG_OWN_REQ];
      run_q <= pwdata[its_pkg::CFG_RUN];
      tsel_q <= pwdata[its_pkg::CFG_TSEL_HI:its_pkg::CFG_TSEL_LO];
    end
  end

  // Command bits held until the engine finishes them; a written one wins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      idle_q <= 1'b0;
      rstart_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else if (wr && paddr == its_pkg::OFS_CONTROL)
    begin
      idle_q <= pwdata[its_pkg::ST_IDLE] || (idle_q && !eng_in.start_det);
      rstart_q <= pwdata[its_pkg::ST_RSTART] || (rstart_q && !eng_in.rstart_done);
      stop_q <= pwdata[its_pkg::ST_STOP] || (stop_q && !eng_in.stop_done);
    end
    else
    begin
      if (eng_in.start_det)
        idle_q <= 1'b0;
      if (eng_in.rstart_done)
        rstart_q <= 1'b0;
      if (eng_in.stop_done)
        stop_q <= 1'b0;
    end
  end

  // Supervision timer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      timer_q <= its_pkg::TIMER_RESET;
      min_done_q <= 1'b0;
    end
    else
    begin
      unique case (mode)
        its_pkg::ITS_OFF:
        begin
          timer_q <= its_pkg::TIMER_RESET;
          min_done_q <= 1'b0;
        end
        its_pkg::ITS_FREE:
        begin
          min_done_q <= 1'b0;
          if (mtick)
            timer_q <= timer_q + 10'h001;
        end
        its_pkg::ITS_MIN:
        begin
          if (eng_in.scl_edge)
          begin
            timer_q <= preload(tsel_q);
            min_done_q <= 1'b0;
          end
          else if (mtick && !min_done_q)
          begin
            timer_q[2:0] <= timer_q[2:0] + 3'h1;
            if (timer_q[2:0] == its_pkg::LOW_MAX)
              min_done_q <= 1'b1;
          end
        end
        its_pkg::ITS_SUPERVISE:
        begin
          if (eng_in.start_det || eng_in.stop_det)
          begin
            timer_q <= its_pkg::TIMER_RESET;
            min_done_q <= 1'b0;
          end
          else if (eng_in.scl_edge)
          begin
            timer_q <= preload(tsel_q);
            min_done_q <= 1'b0;
          end
          else if (mtick && eng_in.frame_active)
          begin
            timer_q <= timer_q + 10'h001;
            if (timer_q[3:0] == 4'(its_pkg::MIN_MARK - 4'h1))
              min_done_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_stat_q <= its_pkg::IRQ_RESET;
    else
    begin
      if (ovf)
        irq_stat_q[its_pkg::IRQ_TFLAG] <= 1'b1;
      else if (wr && ((paddr == its_pkg::OFS_IRQ_STAT && pwdata[its_pkg::IRQ_TFLAG])
          || (paddr == its_pkg::OFS_CONFIG && pwdata[its_pkg::CFG_CLR_TFLAG])))
        irq_stat_q[its_pkg::IRQ_TFLAG] <= 1'b0;
      if (timeout)
        irq_stat_q[its_pkg::IRQ_TIMEOUT] <= 1'b1;
      else if (wr && paddr == its_pkg::OFS_IRQ_STAT && pwdata[its_pkg::IRQ_TIMEOUT])
        irq_stat_q[its_pkg::IRQ_TIMEOUT] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_mask_q <= its_pkg::IRQ_RESET;
    else if (wr && paddr == its_pkg::OFS_IRQ_MASK)
      irq_mask_q <= pwdata[its_pkg::IRQ_TIMEOUT:its_pkg::IRQ_TFLAG];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read-only status image
  always_comb
  begin
    status = 8'h00;
    status[its_pkg::ST_IDLE] = idle_q;
    status[its_pkg::ST_TX_BIT] = eng_in.tx_buffer_bit;
    status[its_pkg::ST_TX_ACT] = eng_in.tx_active_flag;
    status[its_pkg::ST_MK_START] = eng_in.making_start_flag;
    status[its_pkg::ST_MK_STOP] = eng_in.making_stop_flag;
    status[its_pkg::ST_RSTART] = rstart_q;
    status[its_pkg::ST_STOP] = stop_q;
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      its_pkg::OFS_CONFIG: rdata_d = {24'h000000, slave_en_q, own_req_q, 1'b0, run_q, 2'b00, tsel_q};
      its_pkg::OFS_CONTROL: rdata_d = {24'h000000, 1'b0, idle_q, 4'h0, rstart_q, stop_q};
      its_pkg::OFS_STATUS: rdata_d = {24'h000000, status};
      its_pkg::OFS_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
      its_pkg::OFS_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
      its_pkg::OFS_TIMER: rdata_d = {22'h0, timer_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else if (setup && !pwrite)
      rdata_q <= rdata_d;
  end
  assign prdata = rdata_q;

  always_comb
  begin
    eng_out.bus_enable = enabled;
    eng_out.slave_function_enable = slave_en_q;
    eng_out.bus_ownership_request = own_req_q;
    eng_out.scl_timing_select = tsel_q;
    eng_out.idle_cmd = idle_q;
    eng_out.send_repeated_start = rstart_q;
    eng_out.send_stop_cmd = stop_q;
    eng_out.min_time_elapsed = min_done_q;
    eng_out.bus_timeout = timeout;
  end

  // Checks
  sequence s_bare_scl_edge;
    enabled && eng_in.scl_edge && !eng_in.start_det && !eng_in.stop_det;
  endsequence

  sequence s_sup_quiet;
    mode == its_pkg::ITS_SUPERVISE && !eng_in.start_det && !eng_in.stop_det && !eng_in.scl_edge;
  endsequence

  a_off_timer_clear: assert property (@(posedge core_clk) disable iff (rst)
    mode == its_pkg::ITS_OFF |=> timer_q == its_pkg::TIMER_RESET)
    else $error("timer not cleared while off");

  a_reset_config: assert property (@(posedge core_clk)
    rst |=> tsel_q == its_pkg::TSEL_RESET && !slave_en_q && !own_req_q && !run_q)
    else $error("config not cleared by reset");

  a_free_run_count: assert property (@(posedge core_clk) disable iff (rst)
    mode == its_pkg::ITS_FREE && mtick |=> timer_q == 10'($past(timer_q) + 10'h001))
    else $error("free run did not count");

  a_min_upper_hold: assert property (@(posedge core_clk) disable iff (rst)
    mode == its_pkg::ITS_MIN && !eng_in.scl_edge |=> timer_q[9:3] == $past(timer_q[9:3]))
    else $error("upper timer bits moved");

  a_min_no_timeout: assert property (@(posedge core_clk) disable iff (rst)
    mode == its_pkg::ITS_MIN && !wr |-> !eng_out.bus_timeout ##1 $stable(irq_stat_q[its_pkg::IRQ_TIMEOUT]))
    else $error("timeout in min mode");

  a_min_done_set: assert property (@(posedge core_clk) disable iff (rst)
    mode == its_pkg::ITS_MIN && mtick && !eng_in.scl_edge && !min_done_q && timer_q[2:0] == its_pkg::LOW_MAX
    |=> min_done_q)
    else $error("minimum time not flagged");

  a_sup_count: assert property (@(posedge core_clk) disable iff (rst)
    s_sup_quiet ##0 (mtick && eng_in.frame_active) |=> timer_q == 10'($past(timer_q) + 10'h001))
    else $error("supervision timer did not count");

  a_sup_frame_hold: assert property (@(posedge core_clk) disable iff (rst)
    s_sup_quiet ##0 !eng_in.frame_active |=> $stable(timer_q))
    else $error("timer moved outside a frame");

  a_sup_edge_clear: assert property (@(posedge core_clk) disable iff (rst)
    mode == its_pkg::ITS_SUPERVISE && (eng_in.start_det || eng_in.stop_det)
    |=> timer_q == its_pkg::TIMER_RESET)
    else $error("start or stop did not clear timer");

  a_scl_preload: assert property (@(posedge core_clk) disable iff (rst)
    s_bare_scl_edge |=> timer_q == 10'(its_pkg::MIN_MARK - {1'b0, min_count($past(tsel_q))}))
    else $error("wrong preload");

  a_tsel_seven: assert property (@(posedge core_clk) disable iff (rst)
    tsel_q == 2'b10 |-> preload(tsel_q) == 10'h001)
    else $error("code 10 not count seven");

  a_timeout_clears: assert property (@(posedge core_clk) disable iff (rst)
    timeout |=> !slave_en_q && !own_req_q && irq_stat_q[its_pkg::IRQ_TFLAG])
    else $error("timeout did not clear enables");

  a_tflag_clear: assert property (@(posedge core_clk) disable iff (rst)
    wr && paddr == its_pkg::OFS_CONFIG && pwdata[its_pkg::CFG_CLR_TFLAG] && !ovf |=> !irq_stat_q[its_pkg::IRQ_TFLAG])
    else $error("timer flag not cleared");

  a_status_mirror: assert property (@(posedge core_clk) disable iff (rst)
    status[its_pkg::ST_SPARE] == 1'b0 && status[its_pkg::ST_STOP] == stop_q
    && status[its_pkg::ST_MK_START] == eng_in.making_start_flag
    && status[its_pkg::ST_MK_STOP] == eng_in.making_stop_flag)
    else $error("status image wrong");

  a_status_tx: assert property (@(posedge core_clk) disable iff (rst)
    status[its_pkg::ST_IDLE] == idle_q && status[its_pkg::ST_RSTART] == rstart_q
    && status[its_pkg::ST_TX_BIT] == eng_in.tx_buffer_bit && status[its_pkg::ST_TX_ACT] == eng_in.tx_active_flag)
    else $error("status transmitter bits wrong");

  a_stop_held: assert property (@(posedge core_clk) disable iff (rst)
    stop_q && !eng_in.stop_done |=> stop_q)
    else $error("stop command dropped early");

  a_rstart_held: assert property (@(posedge core_clk) disable iff (rst)
    rstart_q && !eng_in.rstart_done |=> rstart_q)
    else $error("repeated start dropped early");

  a_mcycle_div: assert property (@(posedge core_clk) disable iff (rst)
    mtick |=> !mtick [*8])
    else $error("machine tick too frequent");

endmodule : its_supervisor

//--- test/its_engine_model.sv
// Bus engine model that answers start and stop commands
`timescale 1ns/10ps
module its_engine_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Supervisor side
  input its_pkg::its_eng_out_t eo,
  output its_pkg::its_eng_in_t ei,
  // Bench levels and pulses
  input wire logic [6:0] drv
);
  logic [3:0] cnt_q;
  logic busy;
  logic last;
  assign busy = eo.send_repeated_start | eo.send_stop_cmd;
  assign last = cnt_q == 4'h9;
  // Each command takes ten cycles
  always_ff @(posedge core_clk)
  begin
    if (rst || !busy || last)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
  assign ei = {drv, eo.send_repeated_start & !last, eo.send_stop_cmd & !last,
    eo.send_repeated_start & last, eo.send_stop_cmd & last};
endmodule : its_engine_model

//--- test/its_supervisor_test.sv
// Self-checking bench for the supervision timer block
`timescale 1ns/10ps
module its_supervisor_test;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic er;
  } its_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [6:0] drv = 7'h00;
  its_pkg::its_eng_in_t ei;
  its_pkg::its_eng_out_t eo;
  logic [31:0] r;
  logic [31:0] r2;
  logic er;
  int num_errors = 0;
  int tests_run = 0;
  int to_cnt = 0;
  int n0;
  int cnt_tab [4] = '{5, 6, 7, 4};
  logic [7:0] ra [4];
  its_row_t rows [7];

  its_supervisor i_its_supervisor (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_in(ei), .eng_out(eo), .irq(irq));
  its_engine_model i_its_engine_model (.core_clk(core_clk), .rst(rst), .eo(eo), .ei(ei), .drv(drv));

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (eo.bus_timeout === 1'b1)
      to_cnt <= to_cnt + 1;

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt

  task automatic pls(input int b);
    @(posedge core_clk);
    drv[b] <= 1'b1;
    @(posedge core_clk);
    drv[b] <= 1'b0;
  endtask : pls

  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  initial
  begin
    #3500000;
    num_errors++;
    final_report();
  end

  initial
  begin
    ra = '{its_pkg::OFS_CONFIG, its_pkg::OFS_STATUS, its_pkg::OFS_TIMER, its_pkg::OFS_IRQ_STAT};
    rows[0] = '{its_pkg::OFS_CONFIG, 32'hff, 32'hd3, 1'b0};
    rows[1] = '{its_pkg::OFS_CONFIG, 32'h0, 32'h0, 1'b0};
    rows[2] = '{its_pkg::OFS_TIMER, 32'h3ff, 32'h0, 1'b0};
    rows[3] = '{its_pkg::OFS_STATUS, 32'hff, 32'h0, 1'b0};
    rows[4] = '{its_pkg::OFS_IRQ_MASK, 32'h3, 32'h3, 1'b0};
    rows[5] = '{its_pkg::OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0};
    rows[6] = '{8'h18, 32'hff, 32'h0, 1'b1};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset_value", 32'h0, r);
    end
    chk("reset_irq", 32'h0, irq);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("row_data", rows[i].e, r);
      chk("row_err", 32'(rows[i].er), 32'(er));
    end
    // Minimum-time generation for every select code
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, its_pkg::OFS_CONFIG, 32'h80 | 32'(s));
      pls(4);
      wt(cnt_tab[s] * 12 - 13);
      chk("min_early", 32'h0, eo.min_time_elapsed);
      wt(16);
      chk("min_done", 32'h1, eo.min_time_elapsed);
      apb(1'b0, its_pkg::OFS_TIMER, 32'h0);
      chk("timer_hi", 32'h0, r[9:3]);
    end
    chk("eng_slave", 32'h1, eo.slave_function_enable);
    chk("eng_tsel", 32'h3, eo.scl_timing_select);
    drv[5] <= 1'b1;
    apb(1'b1, its_pkg::OFS_CONFIG, 32'hd2);
    pls(4);
    wt(240);
    pls(3);
    apb(1'b0, its_pkg::OFS_TIMER, 32'h0);
    chk("start_clear", 32'h0, r[9:1]);
    wt(240);
    pls(2);
    apb(1'b0, its_pkg::OFS_TIMER, 32'h0);
    chk("stop_clear", 32'h0, r[9:1]);
    drv[5] <= 1'b0;
    apb(1'b0, its_pkg::OFS_TIMER, 32'h0);
    r2 = r;
    wt(117);
    apb(1'b0, its_pkg::OFS_TIMER, 32'h0);
    chk("frame_hold", 32'h0, 32'(r[9:0] - r2[9:0]));
    drv[5] <= 1'b1;
    // Hang supervision timeout for every select code
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, its_pkg::OFS_CONFIG, 32'hd0 | 32'(s));
      pls(4);
      n0 = to_cnt;
      wt((cnt_tab[s] + 1015) * 12 - 1);
      chk("no_timeout", 32'(n0), 32'(to_cnt));
      wt(16);
      chk("timeout", 32'(n0 + 1), 32'(to_cnt));
      apb(1'b0, its_pkg::OFS_CONFIG, 32'h0);
      chk("cfg_cleared", 32'h10 | 32'(s), r);
    end
    apb(1'b0, its_pkg::OFS_IRQ_STAT, 32'h0);
    chk("tout_flag", 32'h1, r[1]);
    chk("eng_own", 32'h0, eo.bus_ownership_request);
    apb(1'b1, its_pkg::OFS_IRQ_MASK, 32'h2);
    wt(1);
    chk("irq_on", 32'h1, irq);
    apb(1'b1, its_pkg::OFS_IRQ_STAT, 32'h3);
    wt(1);
    chk("irq_off", 32'h0, irq);
    // Free-running time base and overflow flag
    apb(1'b0, its_pkg::OFS_TIMER, 32'h0);
    r2 = r;
    wt(117);
    apb(1'b0, its_pkg::OFS_TIMER, 32'h0);
    chk("free_run", 32'ha, 32'(r[9:0] - r2[9:0]));
    wt(12300);
    apb(1'b1, its_pkg::OFS_IRQ_MASK, 32'h1);
    wt(1);
    chk("ovf_irq", 32'h1, irq);
    apb(1'b1, its_pkg::OFS_CONFIG, 32'h30);
    wt(1);
    chk("ovf_clear", 32'h0, irq);
    drv[6] <= 1'b1;
    wt(2);
    chk("master_enable", 32'h1, eo.bus_enable);
    drv[6] <= 1'b0;
    wt(2);
    chk("master_idle", 32'h0, eo.bus_enable);
    // Status readout during start and stop generation
    drv[1:0] <= 2'b11;
    apb(1'b1, its_pkg::OFS_CONTROL, 32'h43);
    apb(1'b0, its_pkg::OFS_STATUS, 32'h0);
    chk("st_busy", 32'h7f, r);
    chk("eng_cmd", 32'h7, 32'({eo.idle_cmd, eo.send_repeated_start, eo.send_stop_cmd}));
    wt(20);
    apb(1'b0, its_pkg::OFS_STATUS, 32'h0);
    chk("st_done", 32'h70, r);
    drv[1:0] <= 2'b00;
    pls(3);
    apb(1'b0, its_pkg::OFS_STATUS, 32'h0);
    chk("st_idle", 32'h0, r);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    apb(1'b0, its_pkg::OFS_CONFIG, 32'h0);
    chk("rereset_cfg", 32'h0, r);
    final_report();
  end
endmodule : its_supervisor_test
